// ---- core/dmsr_core.sv ----
/*
  Debug-mode control/status and resume-pc registers for a one-hart core.
  Assumes the pipeline reports retire, exception and entry events on the
  core clock and accepts halt/resume requests from this block.
*/
`timescale 1ns/1ps
`include "dmsr_defs.svh"

module dmsr_core
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // csr access port from the instruction pipeline
  input wire logic csr_en,
  input wire logic csr_we,
  input wire logic [11:0] csr_addr,
  input wire logic [31:0] csr_wdata,
  output logic [31:0] csr_rdata,
  output logic csr_hit,
  output logic csr_illegal,
  // hart events
  input wire logic nmi_pin,
  input wire dmsr_pkg::dmsr_priv_t cur_priv,
  input wire logic retire,
  input wire logic [31:0] retire_pc,
  input wire logic [31:0] retire_next_pc,
  input wire logic step_exception,
  input wire logic [31:0] exc_pc,
  input wire logic ebreak_hit,
  input wire logic trigger_hit,
  input wire logic trigger_timing,
  input wire logic halt_req,
  input wire logic resume_req,
  // hart control
  output logic debug_mode,
  output logic halt_now,
  output logic resume_now,
  output logic [31:0] resume_pc,
  output logic stop_count,
  output logic step_irq_en,
  output logic ebreak_to_debug
);
  import dmsr_pkg::*;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  dmsr_state_t state_q;
  dmsr_state_t state_d;
  logic [31:0] dpc_q;
  logic step_q;
  logic stepie_q;
  logic stopcnt_q;
  logic brkm_q;
  dmsr_cause_t cause_q;
  dmsr_priv_t priv_q;
  logic nmi_meta_q;
  logic nmi_sync_q;
  logic nmi_pend_q;
  logic enter;
  logic step_done;
  logic ebreak_entry;
  logic [31:0] cap_pc;
  logic [31:0] step_next;
  dmsr_cause_t cap_cause;
  logic sel_ctrl;
  logic sel_pc;
  logic halted;
  logic [31:0] ctrl_word;

  assign halted = (state_q == DMSR_HALTED);
  assign sel_ctrl = (csr_addr == `DMSR_CSR_CTRL_STATUS);
  assign sel_pc = (csr_addr == `DMSR_CSR_RESUME_PC);
  assign ebreak_entry = ebreak_hit && brkm_q && !halted;

  // ----------------------------------------------------------------------
  // nmi pending synchroniser
  // ----------------------------------------------------------------------
  // nmi arrives from a pin; two flops before the pending flag sees it
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      nmi_meta_q <= 1'b0;
      nmi_sync_q <= 1'b0;
      nmi_pend_q <= 1'b0;
    end
    else
    begin
      nmi_meta_q <= nmi_pin;
      nmi_sync_q <= nmi_meta_q;
      nmi_pend_q <= nmi_sync_q;
    end
  end

  // ----------------------------------------------------------------------
  // entry cause and capture address
  // ----------------------------------------------------------------------
  // a trapping step halts on the trap vector side, registers already set
  assign step_done = (state_q == DMSR_STEP_ONE) && (retire || step_exception);
  assign step_next = step_exception ? exc_pc : retire_next_pc;

  dmsr_entry_pc u_entry_pc
  (
    .ebreak_entry(ebreak_entry),
    .trigger_entry(trigger_hit && !halted),
    .trigger_timing(trigger_timing),
    .halt_entry(halt_req && !halted),
    .step_entry(step_done),
    .insn_pc(retire_pc),
    .next_pc(step_done ? step_next : retire_next_pc),
    .capture_pc(cap_pc),
    .cause(cap_cause)
  );

  assign enter = (cap_cause != `DMSR_CAUSE_NONE);

  // ----------------------------------------------------------------------
  // run state machine
  // ----------------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      DMSR_RUN:
      begin
        if (enter)
          state_d = DMSR_HALTED;
      end
      DMSR_STEP_ONE:
      begin
        if (enter)
          state_d = DMSR_HALTED;
      end
      DMSR_HALTED:
      begin
        if (resume_req)
          state_d = step_q ? DMSR_STEP_ONE : DMSR_RUN;
      end
      default:
        state_d = DMSR_RUN;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      state_q <= DMSR_RUN;
    else
      state_q <= state_d;
  end

  // ----------------------------------------------------------------------
  // hart control outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      debug_mode <= 1'b0;
      halt_now <= 1'b0;
      resume_now <= 1'b0;
      resume_pc <= `DMSR_PC_RESET;
    end
    else
    begin
      debug_mode <= (state_d == DMSR_HALTED);
      halt_now <= !halted && enter;
      resume_now <= halted && resume_req;
      // reflects the register as last written, so a debugger's edit counts
      resume_pc <= dpc_q;
    end
  end

  // ----------------------------------------------------------------------
  // resume pc register
  // ----------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (reset)
      dpc_q <= `DMSR_PC_RESET;
    else if (!halted && enter)
      dpc_q <= cap_pc;
    else if (halted && csr_en && csr_we && sel_pc)
      dpc_q <= csr_wdata;
  end

  // ----------------------------------------------------------------------
  // control/status register
  // ----------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      cause_q <= `DMSR_CAUSE_NONE;
      priv_q <= `DMSR_PRIV_RESET;
    end
    else if (!halted && enter)
    begin
      cause_q <= cap_cause;
      priv_q <= cur_priv;
    end
  end

  // writable fields change only from debug mode; step is never touched
  // while the hart runs
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      step_q <= 1'b0;
      stepie_q <= 1'b0;
      stopcnt_q <= 1'b0;
      brkm_q <= 1'b0;
    end
    else if (halted && csr_en && csr_we && sel_ctrl)
    begin
      step_q <= csr_wdata[`DMSR_STEP_BIT];
      stepie_q <= csr_wdata[`DMSR_STEPIE_BIT];
      stopcnt_q <= csr_wdata[`DMSR_STOPCNT_BIT];
      brkm_q <= csr_wdata[`DMSR_BRKM_BIT];
    end
  end

  always_comb
  begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[`DMSR_VER_HI:`DMSR_VER_LO] = `DMSR_VER_VALUE;
    ctrl_word[`DMSR_BRKM_BIT] = brkm_q;
    ctrl_word[`DMSR_STEPIE_BIT] = stepie_q;
    ctrl_word[`DMSR_STOPCNT_BIT] = stopcnt_q;
    ctrl_word[`DMSR_CAUSE_HI:`DMSR_CAUSE_LO] = cause_q;
    ctrl_word[`DMSR_MPRV_EN_BIT] = 1'b0;
    ctrl_word[`DMSR_NMI_PEND_BIT] = nmi_pend_q;
    ctrl_word[`DMSR_STEP_BIT] = step_q;
    ctrl_word[`DMSR_PRIV_HI:`DMSR_PRIV_LO] = priv_q;
  end

  // ----------------------------------------------------------------------
  // csr read path and access check
  // ----------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      csr_rdata <= 32'h0000_0000;
      csr_hit <= 1'b0;
      csr_illegal <= 1'b0;
    end
    else
    begin
      csr_hit <= csr_en && (sel_ctrl || sel_pc);
      csr_illegal <= csr_en && (sel_ctrl || sel_pc) && !halted;
      if (csr_en && halted && sel_pc)
        csr_rdata <= dpc_q;
      else if (csr_en && halted && sel_ctrl)
        csr_rdata <= ctrl_word;
      else
        csr_rdata <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // mode bits to the pipeline
  // ----------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      stop_count <= 1'b0;
      step_irq_en <= 1'b0;
      ebreak_to_debug <= 1'b0;
    end
    else
    begin
      stop_count <= stopcnt_q && (state_d == DMSR_HALTED);
      step_irq_en <= stepie_q;
      ebreak_to_debug <= brkm_q;
    end
  end
endmodule

// ---- core/dmsr_defs.svh ----
/*
  Constants for the debug-mode status and resume-pc block: CSR numbers,
  field positions, reset values and cause codes.
  Assumes inclusion by bare name from the package and the modules.
*/
`ifndef DMSR_DEFS_SVH
`define DMSR_DEFS_SVH

// ----------------------------------------------------------------------
// csr numbers
// ----------------------------------------------------------------------
`define DMSR_CSR_CTRL_STATUS 12'h7B0
`define DMSR_CSR_RESUME_PC 12'h7B1

// ----------------------------------------------------------------------
// control/status field positions
// ----------------------------------------------------------------------
`define DMSR_VER_HI 31
`define DMSR_VER_LO 28
`define DMSR_BRKM_BIT 15
`define DMSR_STEPIE_BIT 11
`define DMSR_STOPCNT_BIT 10
`define DMSR_CAUSE_HI 8
`define DMSR_CAUSE_LO 6
`define DMSR_MPRV_EN_BIT 4
`define DMSR_NMI_PEND_BIT 3
`define DMSR_STEP_BIT 2
`define DMSR_PRIV_HI 1
`define DMSR_PRIV_LO 0

// ----------------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------------
`define DMSR_VER_VALUE 4'h4
`define DMSR_PRIV_RESET 2'h3
`define DMSR_PC_RESET 32'h0000_0000
`define DMSR_INSN_BYTES 32'h0000_0004
`define DMSR_CAUSE_NONE 3'h0
`define DMSR_CAUSE_EBREAK 3'h1
`define DMSR_CAUSE_TRIGGER 3'h2
`define DMSR_CAUSE_HALTREQ 3'h3
`define DMSR_CAUSE_STEP 3'h4

`endif

// ---- core/dmsr_entry_pc.sv ----
/*
  Picks the address the resume-pc register captures on entry to debug
  mode, by entry cause, plus the priority-resolved cause code.
  Assumes pure combinational use beside the top module, same clock.
*/
`timescale 1ns/1ps
`include "dmsr_defs.svh"

module dmsr_entry_pc
(
  // entry causes
  input wire logic ebreak_entry,
  input wire logic trigger_entry,
  input wire logic trigger_timing,
  input wire logic halt_entry,
  input wire logic step_entry,
  // addresses
  input wire logic [31:0] insn_pc,
  input wire logic [31:0] next_pc,
  // selection
  output logic [31:0] capture_pc,
  output dmsr_pkg::dmsr_cause_t cause
);
  import dmsr_pkg::*;

  always_comb
  begin
    capture_pc = next_pc;
    cause = `DMSR_CAUSE_NONE;
    // highest priority first: trigger, ebreak, halt request, step
    if (trigger_entry)
    begin
      cause = `DMSR_CAUSE_TRIGGER;
      capture_pc = trigger_timing ? next_pc : insn_pc;
    end
    else if (ebreak_entry)
    begin
      cause = `DMSR_CAUSE_EBREAK;
      capture_pc = insn_pc;
    end
    else if (halt_entry)
    begin
      cause = `DMSR_CAUSE_HALTREQ;
      capture_pc = next_pc;
    end
    else if (step_entry)
    begin
      cause = `DMSR_CAUSE_STEP;
      capture_pc = next_pc;
    end
  end
endmodule

// ---- core/dmsr_pkg.sv ----
/*
  Types for the debug-mode status and resume-pc block.
  Assumes the constants header is on the include path.
*/
`include "dmsr_defs.svh"

package dmsr_pkg;
  typedef logic [2:0] dmsr_cause_t;
  typedef logic [1:0] dmsr_priv_t;

  // hart run state as seen by this block
  typedef enum logic [1:0]
  {
    DMSR_RUN = 2'b00,
    DMSR_STEP_ONE = 2'b01,
    DMSR_HALTED = 2'b10
  } dmsr_state_t;
endpackage

// ---- tb/dmsr_dbg_model.sv ----
/*
  Debugger model: turns bench commands into halt and resume requests.
  Assumes the core samples requests on the rising edge and ignores a
  resume request while the hart runs.
*/
`timescale 1ns/1ps
module dmsr_dbg_model
(
  // clock
  input wire logic clock,
  // commands
  input wire logic go_halt,
  input wire logic go_resume,
  // requests to the core
  output logic halt_req,
  output logic resume_req
);
  logic halt_q;
  logic resume_q;
  initial {halt_req, resume_req} = 2'b0;
  always @(posedge clock)
  begin
    halt_q <= go_halt;
    resume_q <= go_resume;
  end
  // driven away from the sampling edge; a stray resume is passed on too,
  // so the core's refusal of it can be seen
  always @(negedge clock)
  begin
    halt_req <= halt_q;
    resume_req <= resume_q;
  end
endmodule

// ---- tb/dmsr_monitor.sv ----
/*
  Checker for the csr port and halt/resume handshakes of dmsr_core.
  Assumes it is bound to dmsr_core and sees its ports by name.
*/
`timescale 1ns/1ps
`include "dmsr_defs.svh"
module dmsr_monitor
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // csr port
  input wire logic csr_en,
  input wire logic [11:0] csr_addr,
  input wire logic [31:0] csr_rdata,
  input wire logic csr_hit,
  input wire logic csr_illegal,
  // hart control
  input wire logic halt_req,
  input wire logic resume_req,
  input wire logic debug_mode,
  input wire logic halt_now,
  input wire logic resume_now
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  sequence run_acc;
    csr_en && !debug_mode && csr_addr == `DMSR_CSR_RESUME_PC;
  endsequence
  sequence dbg_acc;
    csr_en && debug_mode && csr_addr == `DMSR_CSR_RESUME_PC;
  endsequence
  sequence leave_req;
    debug_mode && resume_req;
  endsequence
  a_halt_entry: assert property (!debug_mode && halt_req |=> halt_now && debug_mode)
    else $error("halt request did not enter debug mode");
  a_entry_pulse: assert property ($rose(debug_mode) |-> halt_now ##1 !halt_now)
    else $error("entry pulse wrong");
  a_halted_stays: assert property (debug_mode && !resume_req |=> debug_mode && !halt_now)
    else $error("halted hart left or re-entered");
  a_resume_pulse: assert property (leave_req |=> resume_now && !debug_mode ##1 !resume_now)
    else $error("resume handshake wrong");
  a_resume_ignored: assert property (!debug_mode && resume_req |=> !resume_now)
    else $error("resume while running");
  a_illegal_running: assert property (run_acc |=> csr_illegal && csr_hit && csr_rdata == 32'h0)
    else $error("running access not refused");
  a_halted_legal: assert property (dbg_acc |=> csr_hit && !csr_illegal)
    else $error("halted access refused");
  a_unmapped_miss: assert property (csr_en && csr_addr[11:1] != 11'h3D8 |=> !csr_hit && csr_rdata == 32'h0)
    else $error("unmapped access hit");
endmodule

bind dmsr_core dmsr_monitor dmsr_monitor_inst (.clock, .reset, .csr_en, .csr_addr, .csr_rdata,
  .csr_hit, .csr_illegal, .halt_req, .resume_req, .debug_mode, .halt_now, .resume_now);

// ---- tb/testbench.sv ----
/*
  Testbench for dmsr_core: csr read/write tasks and hart-event tasks.
  Assumes the package, core and models are compiled first.
*/
`timescale 1ns/1ps
module testbench;
  import dmsr_pkg::*;
  logic clock, reset, csr_en, csr_we, nmi_pin, retire, step_exception, ebreak_hit;
  logic trigger_hit, trigger_timing, go_halt, go_resume, halt_req, resume_req;
  logic csr_hit, csr_illegal, debug_mode, halt_now, resume_now;
  logic stop_count, step_irq_en, ebreak_to_debug;
  logic [11:0] csr_addr;
  logic [31:0] csr_wdata, csr_rdata, retire_pc, retire_next_pc, exc_pc, resume_pc;
  dmsr_priv_t cur_priv;
  int num_errors, n_tests;
  dmsr_core dmsr_core_inst (.clock, .reset, .csr_en, .csr_we, .csr_addr, .csr_wdata,
    .csr_rdata, .csr_hit, .csr_illegal, .nmi_pin, .cur_priv, .retire, .retire_pc,
    .retire_next_pc, .step_exception, .exc_pc, .ebreak_hit, .trigger_hit, .trigger_timing,
    .halt_req, .resume_req, .debug_mode, .halt_now, .resume_now, .resume_pc,
    .stop_count, .step_irq_en, .ebreak_to_debug);
  dmsr_dbg_model dmsr_dbg_model_inst (.clock, .go_halt, .go_resume, .halt_req, .resume_req);
  initial
  begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic csr(logic we, logic [11:0] a, logic [31:0] d, logic [31:0] exp, logic ill);
    @(negedge clock);
    {csr_en, csr_we, csr_addr, csr_wdata} = {1'b1, we, a, d};
    @(negedge clock);
    csr_en = 0;
    chk("csr illegal", {31'h0, ill}, {31'h0, csr_illegal});
    if (!we)
      chk("csr rdata", exp, csr_rdata);
  endtask
  task automatic wait_mode(logic m);
    int i;
    i = 0;
    while (debug_mode !== m && i < 20)
    begin
      @(negedge clock);
      i++;
    end
    chk("debug mode", {31'h0, m}, {31'h0, debug_mode});
  endtask
  task automatic enter(logic [4:0] ev, logic [31:0] pc, logic [31:0] nx);
    @(negedge clock);
    {trigger_hit, ebreak_hit, retire, step_exception, go_halt} = ev;
    {retire_pc, retire_next_pc} = {pc, nx};
    @(negedge clock);
    {trigger_hit, ebreak_hit, retire, step_exception, go_halt} = 5'h0;
    wait_mode(1);
  endtask
  task automatic leave(logic [31:0] exp_pc);
    @(negedge clock);
    go_resume = 1;
    @(negedge clock);
    go_resume = 0;
    wait_mode(0);
    chk("resume now", 32'h1, {31'h0, resume_now});
    chk("resume pc", exp_pc, resume_pc);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial
  begin
    {csr_en, csr_we, nmi_pin, retire, step_exception, ebreak_hit} = 6'h0;
    {trigger_hit, trigger_timing, go_halt, go_resume} = 4'h0;
    {csr_addr, csr_wdata, retire_pc, retire_next_pc, exc_pc} = '0;
    cur_priv = 2'h0;
    reset = 1;
    repeat (10) @(negedge clock);
    reset = 0;
    chk("reset resume pc", 32'h0, resume_pc);
    csr(0, 12'h7B1, 0, 0, 1);
    // a resume while running must be ignored
    @(negedge clock);
    go_resume = 1;
    @(negedge clock);
    go_resume = 0;
    @(negedge clock);
    chk("stray resume now", 32'h0, {31'h0, resume_now});
    chk("stray debug mode", 32'h0, {31'h0, debug_mode});
    $display("test reset done");
    enter(5'h01, 32'h10, 32'h100);
    csr(0, 12'h7B1, 0, 32'h100, 0);
    csr(0, 12'h7B0, 0, 32'h4000_00C0, 0);
    csr(0, 12'h7A0, 0, 0, 0);
    csr(1, 12'h7B0, 32'h0000_8014, 0, 0);
    csr(0, 12'h7B0, 0, 32'h4000_80C4, 0);
    nmi_pin = 1;
    repeat (4) @(negedge clock);
    chk("ebreak to debug", 32'h1, {31'h0, ebreak_to_debug});
    chk("step irq en", 32'h0, {31'h0, step_irq_en});
    csr(0, 12'h7B0, 0, 32'h4000_80CC, 0);
    nmi_pin = 0;
    csr(1, 12'h7B1, 32'h200, 0, 0);
    $display("test halt done");
    leave(32'h200);
    cur_priv = 2'h3;
    enter(5'h04, 32'h200, 32'h204);
    csr(0, 12'h7B1, 0, 32'h204, 0);
    csr(0, 12'h7B0, 0, 32'h4000_8107, 0);
    leave(32'h204);
    exc_pc = 32'h80;
    enter(5'h02, 32'h204, 32'h208);
    csr(0, 12'h7B1, 0, 32'h80, 0);
    csr(1, 12'h7B0, 32'h0000_8C00, 0, 0);
    @(negedge clock);
    chk("stop count halted", 32'h1, {31'h0, stop_count});
    chk("step irq en set", 32'h1, {31'h0, step_irq_en});
    $display("test step done");
    leave(32'h80);
    chk("stop count running", 32'h0, {31'h0, stop_count});
    enter(5'h08, 32'h300, 32'h304);
    csr(0, 12'h7B1, 0, 32'h300, 0);
    csr(0, 12'h7B0, 0, 32'h4000_8C43, 0);
    for (int t = 0; t < 2; t++)
    begin
      leave(t ? 32'h400 : 32'h300);
      trigger_timing = t[0];
      enter(5'h18, 32'h400, 32'h404);
      csr(0, 12'h7B1, 0, t ? 32'h404 : 32'h400, 0);
      csr(0, 12'h7B0, 0, 32'h4000_8C83, 0);
    end
    $display("test entry causes done");
    give_verdict();
  end
  initial
  begin
    #100000;
    num_errors++;
    give_verdict();
  end
endmodule
